// *** inc/adcsr_pkg.sv ***
`default_nettype none
package adcsr_pkg;
  // ----------------------------------------
  // Register addresses (low seven bits of the control byte)
  // ----------------------------------------
  localparam logic [6:0] ADDR_MODE = 7'h10;
  localparam logic [6:0] ADDR_MASK = 7'h11;
  localparam logic [6:0] ADDR_START = 7'h12;
  localparam logic [6:0] ADDR_STATUS = 7'h13;
  localparam logic [2:0] ADDR_DATA_PAGE = 3'h0;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_WRITE_BIT = 7;
  localparam int MODE_OSC_BIT = 5;
  localparam int MODE_REF_BIT = 4;
  localparam int MODE_8BIT_BIT = 3;
  localparam int MODE_IRQEN_BIT = 2;
  localparam int MODE_HI_BIT = 1;
  localparam int MODE_LO_BIT = 0;
  localparam int START_RUN_BIT = 7;
  localparam int START_LOAD_BIT = 4;
  localparam int START_CH_HI = 3;
  localparam int START_CH_LO = 1;
  localparam int START_HL_BIT = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] START_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ----------------------------------------
  // Conversion timing in oscillator ticks, internal oscillator divider
  // ----------------------------------------
  localparam logic [4:0] CONV_TICKS_WIDE = 5'h0B;
  localparam logic [4:0] CONV_TICKS_NARROW = 5'h09;
  localparam logic [3:0] INT_OSC_DIV = 4'h5;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {ADCSR_IDLE, ADCSR_SINGLE, ADCSR_SCAN, ADCSR_CONT} adcsr_mode_t;
  typedef enum logic [1:0] {ADCSR_ST_WAIT, ADCSR_ST_CONV, ADCSR_ST_GAP} adcsr_conv_t;
endpackage : adcsr_pkg
`default_nettype wire

// *** hw/adcsr_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsr_core (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link, sclk owns its own domain
  input wire logic sclk,
  input wire logic chipEnable,
  input wire logic mosi,
  output logic miso,
  // Interrupt pin, open drain
  output logic irqPinOut,
  output logic irqPinOe,
  // Converter front end
  input wire logic oscIn,
  output logic oscEnable,
  output logic refSelect,
  output logic [2:0] chanSelect,
  input wire logic [9:0] analogCode
);
  import adcsr_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] nextChan(input logic [2:0] ptr, input logic [7:0] mask);
    logic [2:0] found;
    logic [2:0] cand;
    logic hit;
    found = ptr + 3'd1;
    hit = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      cand = ptr + 3'(k);
      if (!hit && mask[cand]) begin
        found = cand;
        hit = 1'b1;
      end
    end
    return found;
  endfunction : nextChan

  function automatic logic allCovered(input logic [7:0] mask, input logic [7:0] fresh);
    return (mask != MASK_RESET) && ((mask & ~fresh) == MASK_RESET);
  endfunction : allCovered

  // ----------------------------------------
  // Link domain: byte shifter
  // ----------------------------------------
  logic linkRst_n;
  logic [2:0] bitCnt_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] rxHold_reg;
  logic rxToggle_reg;
  logic [7:0] txByte_reg;

  assign linkRst_n = reset_n & chipEnable;

  always_ff @(posedge sclk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      bitCnt_reg <= 3'd0;
      rxShift_reg <= READ_ZERO;
    end else begin
      bitCnt_reg <= bitCnt_reg + 3'd1;
      rxShift_reg <= {rxShift_reg[6:0], mosi};
    end
  end

  // Toggle is not reset by chip enable, else a frame end would look like a byte
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      rxHold_reg <= READ_ZERO;
      rxToggle_reg <= 1'b0;
    end else if (bitCnt_reg == 3'd7) begin
      rxHold_reg <= {rxShift_reg[6:0], mosi};
      rxToggle_reg <= ~rxToggle_reg;
    end
  end

  // Transmit byte is quasi-static: it only changes in the gap between bytes
  assign miso = txByte_reg[3'd7 - bitCnt_reg];

  // ----------------------------------------
  // Crossings into clk
  // ----------------------------------------
  logic [2:0] togSync_reg;
  logic [1:0] ceSync_reg;
  logic [2:0] oscSync_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      togSync_reg <= 3'd0;
      ceSync_reg <= 2'd0;
      oscSync_reg <= 3'd0;
    end else begin
      togSync_reg <= {togSync_reg[1:0], rxToggle_reg};
      ceSync_reg <= {ceSync_reg[0], chipEnable};
      oscSync_reg <= {oscSync_reg[1:0], oscIn};
    end
  end

  logic byteEvent;
  logic ceLevel;
  assign byteEvent = togSync_reg[1] ^ togSync_reg[2];
  assign ceLevel = ceSync_reg[1];

  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic firstByte_reg;
  logic isWrite_reg;
  logic [6:0] addr_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      firstByte_reg <= 1'b1;
      isWrite_reg <= 1'b0;
      addr_reg <= 7'h00;
    end else if (!ceLevel) begin
      firstByte_reg <= 1'b1;
    end else if (byteEvent && firstByte_reg) begin
      firstByte_reg <= 1'b0;
      isWrite_reg <= rxHold_reg[CTRL_WRITE_BIT];
      addr_reg <= rxHold_reg[6:0];
    end
  end

  // ----------------------------------------
  // Decode of bus events
  // ----------------------------------------
  logic [7:0] modeReg_reg;
  logic [7:0] maskReg_reg;
  logic [7:0] startReg_reg;
  adcsr_mode_t modeSel;
  logic eightBit;
  logic hdrEvent;
  logic dataEvent;
  logic wrMode;
  logic wrMask;
  logic wrStart;
  logic rdData;
  logic rdLow;
  logic rdStatus;
  logic clearAll;
  logic hdrDataRead;

  assign modeSel = adcsr_mode_t'(modeReg_reg[MODE_HI_BIT:MODE_LO_BIT]);
  assign eightBit = modeReg_reg[MODE_8BIT_BIT];
  assign refSelect = modeReg_reg[MODE_REF_BIT];
  assign hdrEvent = byteEvent & ceLevel & firstByte_reg;
  assign dataEvent = byteEvent & ceLevel & ~firstByte_reg;
  assign hdrDataRead = hdrEvent & ~rxHold_reg[CTRL_WRITE_BIT] & (rxHold_reg[6:4] == ADDR_DATA_PAGE);
  assign wrMode = dataEvent & isWrite_reg & (addr_reg == ADDR_MODE);
  assign wrMask = dataEvent & isWrite_reg & (addr_reg == ADDR_MASK);
  assign wrStart = dataEvent & isWrite_reg & (addr_reg == ADDR_START);
  assign rdData = dataEvent & ~isWrite_reg & (addr_reg[6:4] == ADDR_DATA_PAGE);
  assign rdStatus = dataEvent & ~isWrite_reg & (addr_reg == ADDR_STATUS);
  assign clearAll = wrMode | wrMask;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeReg_reg <= MODE_RESET;
      maskReg_reg <= MASK_RESET;
      startReg_reg <= START_RESET;
    end else begin
      if (wrMode) begin
        modeReg_reg <= rxHold_reg;
      end
      if (wrMask) begin
        maskReg_reg <= rxHold_reg;
      end
      if (wrStart) begin
        startReg_reg <= rxHold_reg;
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  adcsr_conv_t state_reg;
  logic [2:0] chanPtr_reg;
  logic hlLow_reg;
  logic [2:0] convChan_reg;
  logic [4:0] tickCnt_reg;
  logic [3:0] divCnt_reg;
  logic [7:0] fresh_reg;
  logic [7:0] overrun_reg;
  logic [9:0] result_reg [8];
  logic intFlag_reg;
  logic allDone_reg;
  logic converting_reg;
  logic oscInternal;
  logic tick;
  logic done;
  logic [7:0] freshAfter;
  logic doneAll;
  logic startSar;
  logic startRead;
  logic [2:0] sarChan;
  logic [4:0] lastTick;

  assign rdLow = rdData & (eightBit | hlLow_reg);
  assign oscInternal = modeReg_reg[MODE_OSC_BIT];
  assign oscEnable = oscInternal & (modeSel != ADCSR_IDLE) & (state_reg == ADCSR_ST_CONV);
  assign tick = oscInternal ? (divCnt_reg == INT_OSC_DIV - 4'd1) : (oscSync_reg[1] & ~oscSync_reg[2]);
  assign lastTick = eightBit ? CONV_TICKS_NARROW : CONV_TICKS_WIDE;
  assign done = (state_reg == ADCSR_ST_CONV) & tick & (tickCnt_reg == lastTick) & ~clearAll;
  assign freshAfter = fresh_reg | (8'h01 << convChan_reg);
  assign doneAll = allCovered(maskReg_reg, freshAfter);
  assign sarChan = rxHold_reg[START_LOAD_BIT] ? rxHold_reg[START_CH_HI:START_CH_LO] : chanPtr_reg;
  assign startSar = wrStart & rxHold_reg[START_RUN_BIT] & (modeSel != ADCSR_IDLE) & (state_reg == ADCSR_ST_WAIT);
  assign startRead = rdLow & (modeSel == ADCSR_SINGLE) & (maskReg_reg != MASK_RESET) & (state_reg == ADCSR_ST_WAIT);
  assign chanSelect = convChan_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_reg <= 4'd0;
    end else if (!oscEnable || tick) begin
      divCnt_reg <= 4'd0;
    end else begin
      divCnt_reg <= divCnt_reg + 4'd1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ADCSR_ST_WAIT;
      tickCnt_reg <= 5'd0;
      convChan_reg <= 3'd0;
    end else begin
      case (state_reg)
        ADCSR_ST_WAIT: begin
          tickCnt_reg <= 5'd0;
          if (startSar) begin
            state_reg <= ADCSR_ST_CONV;
            convChan_reg <= sarChan;
          end else if (startRead) begin
            state_reg <= ADCSR_ST_CONV;
            convChan_reg <= nextChan(chanPtr_reg, maskReg_reg);
          end
        end
        ADCSR_ST_CONV: begin
          if (clearAll) begin
            state_reg <= ADCSR_ST_WAIT;
          end else if (done) begin
            tickCnt_reg <= 5'd0;
            if (startReg_reg[START_RUN_BIT] && ((modeSel == ADCSR_CONT) || (modeSel == ADCSR_SCAN && !doneAll))) begin
              state_reg <= ADCSR_ST_GAP;
              convChan_reg <= nextChan(convChan_reg, maskReg_reg);
            end else begin
              state_reg <= ADCSR_ST_WAIT;
            end
          end else if (tick) begin
            tickCnt_reg <= tickCnt_reg + 5'd1;
          end
        end
        ADCSR_ST_GAP: begin
          state_reg <= clearAll ? ADCSR_ST_WAIT : ADCSR_ST_CONV;
        end
        default: begin
          state_reg <= ADCSR_ST_WAIT;
        end
      endcase
    end
  end

  // Pointer: jammed by data-address headers and start writes, stepped by reads and scans
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chanPtr_reg <= 3'd0;
      hlLow_reg <= 1'b0;
    end else if (hdrDataRead) begin
      chanPtr_reg <= rxHold_reg[START_CH_HI:START_CH_LO];
      hlLow_reg <= eightBit | rxHold_reg[START_HL_BIT];
    end else if (wrStart && rxHold_reg[START_LOAD_BIT]) begin
      chanPtr_reg <= rxHold_reg[START_CH_HI:START_CH_LO];
      hlLow_reg <= eightBit | rxHold_reg[START_HL_BIT];
    end else if (rdLow) begin
      chanPtr_reg <= nextChan(chanPtr_reg, maskReg_reg);
      hlLow_reg <= eightBit;
    end else if (rdData) begin
      hlLow_reg <= 1'b1;
    end else if (done && modeSel != ADCSR_SINGLE) begin
      chanPtr_reg <= nextChan(convChan_reg, maskReg_reg);
    end else if (done) begin
      chanPtr_reg <= convChan_reg;
    end
  end

  // ----------------------------------------
  // Per-channel results and flags
  // ----------------------------------------
  for (genvar ch = 0; ch < 8; ch++) begin : gChan
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        fresh_reg[ch] <= 1'b0;
        overrun_reg[ch] <= 1'b0;
        result_reg[ch] <= 10'h000;
      end else if (clearAll) begin
        fresh_reg[ch] <= 1'b0;
        overrun_reg[ch] <= 1'b0;
      end else if (done && convChan_reg == 3'(ch)) begin
        fresh_reg[ch] <= 1'b1;
        overrun_reg[ch] <= overrun_reg[ch] | (fresh_reg[ch] & ~(rdLow && chanPtr_reg == 3'(ch)));
        result_reg[ch] <= eightBit ? {2'b00, analogCode[9:2]} : analogCode;
      end else if (rdLow && chanPtr_reg == 3'(ch)) begin
        fresh_reg[ch] <= 1'b0;
        overrun_reg[ch] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Hardware set wins over a read clear in the same cycle; a mode or mask write suppresses the set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      intFlag_reg <= 1'b0;
    end else if (done && (modeSel == ADCSR_SINGLE || (modeSel == ADCSR_SCAN && doneAll))) begin
      intFlag_reg <= 1'b1;
    end else if (rdStatus || rdData || clearAll) begin
      intFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      allDone_reg <= 1'b0;
    end else if (done && doneAll) begin
      allDone_reg <= 1'b1;
    end else if (rdData || clearAll) begin
      allDone_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converting_reg <= 1'b0;
    end else if (startSar || startRead || (state_reg == ADCSR_ST_GAP && !clearAll)) begin
      converting_reg <= 1'b1;
    end else if (done && !(modeSel == ADCSR_CONT && !startReg_reg[START_RUN_BIT])) begin
      converting_reg <= 1'b0;
    end else if (clearAll || rdData || (wrStart && (rxHold_reg[START_RUN_BIT] || rxHold_reg[START_LOAD_BIT]))) begin
      converting_reg <= 1'b0;
    end
  end

  // Pin released in idle, continuous scan, or with pin enable clear
  assign irqPinOut = 1'b0;
  assign irqPinOe = intFlag_reg & modeReg_reg[MODE_IRQEN_BIT]
                    & (modeSel == ADCSR_SINGLE || modeSel == ADCSR_SCAN);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] readValue;
  logic txLoad_reg;

  always_comb begin
    readValue = READ_ZERO;
    case (addr_reg)
      ADDR_MODE: readValue = modeReg_reg;
      ADDR_MASK: readValue = maskReg_reg;
      ADDR_START: readValue = {startReg_reg[7:1], hlLow_reg};
      ADDR_STATUS: readValue = {intFlag_reg, allDone_reg, converting_reg, 1'b0, chanPtr_reg, 1'b0};
      default: begin
        if (addr_reg[6:4] == ADDR_DATA_PAGE) begin
          if (hlLow_reg) begin
            readValue = result_reg[chanPtr_reg][7:0];
          end else begin
            readValue = {fresh_reg[chanPtr_reg], overrun_reg[chanPtr_reg], 4'h0, result_reg[chanPtr_reg][9:8]};
          end
        end
      end
    endcase
  end

  // Reloaded one cycle after every byte, so a polled status byte is always current
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txLoad_reg <= 1'b0;
      txByte_reg <= READ_ZERO;
    end else begin
      txLoad_reg <= byteEvent & ceLevel;
      if (txLoad_reg) begin
        txByte_reg <= readValue;
      end
    end
  end
endmodule : adcsr_core
`default_nettype wire

// *** tb/adcsr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsr_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link
  input wire logic sclk,
  input wire logic chipEnable,
  input wire logic mosi,
  input wire logic miso,
  // Interrupt pin
  input wire logic irqPinOut,
  input wire logic irqPinOe,
  // Converter front end
  input wire logic oscIn,
  input wire logic oscEnable,
  input wire logic refSelect,
  input wire logic [2:0] chanSelect,
  input wire logic [9:0] analogCode
);
  logic [3:0] ceAge_reg;
  logic [3:0] oscAge_reg;
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ----
  // Cycles since the last frame and since the oscillator last ran
  // ----
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ceAge_reg <= 4'hF;
    end else if (chipEnable) begin
      ceAge_reg <= 4'h0;
    end else if (ceAge_reg != 4'hF) begin
      ceAge_reg <= ceAge_reg + 4'h1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oscAge_reg <= 4'hF;
    end else if (oscEnable) begin
      oscAge_reg <= 4'h0;
    end else if (oscAge_reg != 4'hF) begin
      oscAge_reg <= oscAge_reg + 4'h1;
    end
  end
  // ----
  // Assertions
  // ----
  sequence convRun;
    oscEnable [*8];
  endsequence
  sequence chanHeld;
    $stable(chanSelect) [*8];
  endsequence
  pin_drain_a: assert property (irqPinOut == 1'b0)
    else $error("Interrupt pin data not low");
  reset_quiet_a: assert property ($rose(reset_n) |-> !irqPinOe && !oscEnable && !refSelect && chanSelect == 3'h0)
    else $error("Outputs not quiet after reset");
  irq_clear_a: assert property ($fell(irqPinOe) |-> ceAge_reg < 4'h8)
    else $error("Interrupt pin released without a host access");
  // Holds only while the internal oscillator is chosen whenever the pin is enabled
  irq_done_a: assert property ($rose(irqPinOe) |-> oscAge_reg < 4'h3)
    else $error("Interrupt pin raised without a finished conversion");
  osc_min_a: assert property ($rose(oscEnable) |=> convRun)
    else $error("Oscillator stopped too early");
  osc_max_a: assert property ($rose(oscEnable) |-> ##[1:100] !oscEnable)
    else $error("Oscillator kept running past one conversion");
  chan_hold_a: assert property ($rose(oscEnable) |-> ##3 chanHeld)
    else $error("Channel select moved during a conversion");
  ref_write_a: assert property ($changed(refSelect) |-> ceAge_reg < 4'h8)
    else $error("Reference select changed without a mode write");
endmodule : adcsr_monitor
bind adcsr_core adcsr_monitor mon_u (.clk, .reset_n, .sclk, .chipEnable, .mosi, .miso, .irqPinOut, .irqPinOe,
  .oscIn, .oscEnable, .refSelect, .chanSelect, .analogCode);
`default_nettype wire

// *** tb/adcsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcsr_host (
  // Serial link
  output logic sclk,
  output logic chipEnable,
  output logic mosi,
  input wire logic miso,
  // Captured read bytes
  output logic [7:0] rxByte,
  output logic rxStrobe
);
  initial begin
    sclk = 1'b0;
    chipEnable = 1'b0;
    mosi = 1'b0;
    rxByte = 8'h00;
    rxStrobe = 1'b0;
  end
  // ----
  // Byte and frame transfers, clock idles low outside frames
  // ----
  task automatic shift(input logic [7:0] txd, output logic [7:0] rxd);
    for (int i = 7; i >= 0; i--) begin
      mosi = txd[i];
      #15;
      rxd[i] = miso;
      sclk = 1'b1;
      #15;
      sclk = 1'b0;
    end
    #700; // Four system clocks are needed before the next byte
  endtask : shift
  task automatic frame(input logic [7:0] ctrl, input int n, input logic [7:0] wdat);
    logic [7:0] rxd;
    chipEnable = 1'b1;
    #30;
    shift(ctrl, rxd);
    repeat (n) begin
      shift(wdat, rxd);
      if (!ctrl[7]) begin
        rxByte = rxd;
        rxStrobe = 1'b1;
        #5;
        rxStrobe = 1'b0;
      end
    end
    chipEnable = 1'b0;
    mosi = ~mosi; // A released line must not look like held data
    #400;
  endtask : frame
endmodule : adcsr_host
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcsr_pkg::*;
  logic clk, reset_n, sclk, chipEnable, mosi, miso, irqPinOut, irqPinOe, oscIn, oscEnable, refSelect, rxStrobe;
  logic [2:0] chanSelect;
  logic [9:0] analogCode, code;
  logic [7:0] rxByte;
  logic [7:0] expQ[$];
  logic [31:0] seed;
  logic [1:0] oscDiv = 2'h0;
  int numErrors, nChecks;
  adcsr_core dut_u (.clk, .reset_n, .sclk, .chipEnable, .mosi, .miso, .irqPinOut, .irqPinOe, .oscIn, .oscEnable,
    .refSelect, .chanSelect, .analogCode);
  adcsr_host host_u (.sclk, .chipEnable, .mosi, .miso, .rxByte, .rxStrobe);
  // ----
  // Clock, external oscillator and helpers
  // ----
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    oscDiv <= oscDiv + 2'h1;
    oscIn <= oscDiv[1];
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    nChecks++;
    if (got !== want) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic stopTest;
    $display("Summary: %0d checks, %0d errors", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stopTest
  task automatic ex(input logic [7:0] v);
    expQ.push_back(v);
  endtask : ex
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.frame({1'b1, a}, 1, d);
  endtask : wr
  task automatic rd(input logic [6:0] a, input int n);
    host_u.frame({1'b0, a}, n, 8'h00);
  endtask : rd
  task automatic pin(input logic v);
    chk({7'h00, irqPinOe}, {7'h00, v});
  endtask : pin
  task automatic newCode;
    seed = xs(seed);
    code = seed[9:0];
    @(posedge clk);
    analogCode <= code;
  endtask : newCode
  task automatic waitIrq;
    int k;
    k = 0;
    while (irqPinOe !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (irqPinOe !== 1'b1) begin
      pin(1'b1);
      stopTest();
    end
  endtask : waitIrq
  // Oldest expectation is matched to each byte read back
  always @(posedge rxStrobe) begin
    if (expQ.size() == 0) begin
      chk(rxByte, ~rxByte);
    end else begin
      chk(rxByte, expQ.pop_front());
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    reset_n = 1'b0;
    analogCode = 10'h000;
    seed = 32'h156c_bd47;
    numErrors = 0;
    nChecks = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    ex(8'h00);
    ex(8'h00);
    rd(ADDR_STATUS, 2);
    ex(8'h00);
    rd(ADDR_MODE, 1);
    ex(8'h00);
    rd(7'h20, 1);
    wr(ADDR_MASK, 8'h05);
    wr(ADDR_MODE, 8'h25);
    ex(8'h25);
    rd(ADDR_MODE, 1);
    newCode();
    wr(ADDR_START, 8'h90);
    ex(8'h20);
    rd(ADDR_STATUS, 1);
    waitIrq();
    ex(8'h80);
    ex(8'h00);
    rd(ADDR_STATUS, 2);
    pin(1'b0);
    newCode();
    wr(ADDR_START, 8'h90);
    waitIrq();
    ex({6'h30, code[9:8]});
    ex(code[7:0]);
    newCode();
    rd(7'h00, 2);
    waitIrq();
    ex({6'h20, code[9:8]});
    ex(code[7:0]);
    rd(7'h04, 2);
    wr(ADDR_MODE, 8'h3D);
    chk({7'h00, refSelect}, 8'h01);
    newCode();
    wr(ADDR_START, 8'h90);
    waitIrq();
    ex(code[9:2]);
    rd(7'h00, 1);
    chk({5'h00, chanSelect}, 8'h02);
    ex(8'h24);
    rd(ADDR_STATUS, 1);
    wr(ADDR_MODE, 8'h00);
    pin(1'b0);
    chk({7'h00, oscEnable}, 8'h00);
    wr(ADDR_MODE, 8'h02);
    @(posedge clk);
    analogCode <= 10'h3FF;
    wr(ADDR_START, 8'h90);
    repeat (400) @(posedge clk); // Two channels of twelve ticks each fit well inside
    pin(1'b0);
    ex(8'hC0);
    rd(ADDR_STATUS, 1);
    wr(ADDR_START, 8'h10);
    ex(8'h83);
    ex(8'hFF);
    ex(8'h83);
    ex(8'hFF);
    rd(7'h00, 4);
    ex(8'h00);
    rd(ADDR_STATUS, 1);
    // Continuous scan never raises the interrupt; a run-clear stop keeps flags and results
    wr(ADDR_MODE, 8'h07);
    wr(ADDR_START, 8'h90);
    repeat (200) @(posedge clk);
    pin(1'b0);
    wr(ADDR_START, 8'h00);
    repeat (100) @(posedge clk);
    wr(ADDR_START, 8'h10);
    ex(8'h40);
    rd(ADDR_STATUS, 1);
    ex(8'h10);
    rd(ADDR_START, 1);
    ex(8'hC3);
    ex(8'hFF);
    rd(7'h00, 2);
    wr(ADDR_MODE, 8'h00);
    ex(8'h05);
    rd(ADDR_MASK, 1);
    repeat (20) @(posedge clk);
    chk(8'(expQ.size()), 8'h00);
    stopTest();
  end
endmodule : testbench
`default_nettype wire
